/* include/tws_pkg.sv */
// package: register map, field layout and carriers of the timer status slice
package tws_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_EN_CLR  = 8'h08;
   localparam logic [7:0] IDX_EN_SET  = 8'h09;
   localparam logic [7:0] IDX_FLAGS   = 8'h0a;
   localparam logic [7:0] IDX_STATUS  = 8'h0b;
   localparam logic [7:0] IDX_WAVE    = 8'h0c;
   localparam logic [7:0] IDX_POLAR   = 8'h0d;
   localparam int         ADDR_W      = 8;
   localparam int         IDX_SHIFT   = 2;

   // bit positions shared by enables, flags and status
   localparam int BIT_OVF   = 0;
   localparam int BIT_ERR   = 1;
   localparam int BIT_MC0   = 4;
   localparam int BIT_STOP  = 0;
   localparam int BIT_CLNT  = 1;
   localparam int BIT_BUFV0 = 4;
   localparam int NUM_CH    = 2;

   // reset values and masks
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_FLAGS  = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h01;
   localparam logic [7:0] RST_WAVE   = 8'h00;
   localparam logic [7:0] RST_POLAR  = 8'h00;
   localparam logic [7:0] IRQ_MASK   = 8'h33;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // waveform select settings
   typedef enum logic [1:0] {
      WG_NORMAL_FREQ  = 2'h0,
      WG_MATCH_FREQ   = 2'h1,
      WG_NORMAL_PULSE = 2'h2,
      WG_MATCH_PULSE  = 2'h3
   } tws_wave_t;

   // counter width configuration
   typedef enum logic [1:0] {
      CNT_8BIT,
      CNT_16BIT,
      CNT_32BIT
   } tws_cnt_mode_t;

   // top value source handed to the counter core
   typedef enum logic [1:0] {
      TOP_MAX,
      TOP_PERIOD,
      TOP_CH0
   } tws_top_t;

   // register selected by an address
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_EN_CLR,
      SEL_EN_SET,
      SEL_FLAGS,
      SEL_STATUS,
      SEL_WAVE,
      SEL_POLAR
   } tws_sel_t;

   // events and configuration from the counter core
   typedef struct packed {
      logic [NUM_CH-1:0] match;        // compare match pulse
      logic [NUM_CH-1:0] capture;      // captured value stored pulse
      logic [NUM_CH-1:0] capture_mode; // channel in capture operation
      logic [NUM_CH-1:0] buf_write;    // software wrote channel_buffer
      logic [NUM_CH-1:0] cc_read;      // software read channel_value
      logic              overflow;     // overflow/underflow pulse
      logic              wrap;         // counter wraparound pulse
      logic              update;       // hardware update condition pulse
      logic              stop_cmd;     // stop command pulse
      logic              start_cmd;    // start/retrigger pulse
      logic              enable;       // counter enabled level
      logic              single_shot;  // single-shot configured
      logic              update_lock;  // update lock level
      logic              host_32bit;   // host counter runs 32-bit
      logic              is_client;    // this counter is the client
      tws_cnt_mode_t     cnt_mode;     // counter width
   } tws_core_t;

endpackage

/* hw/tws_wave_chan.sv */
// one channel of waveform generation with polarity flip
`timescale 1ns/1ps
module tws_wave_chan (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // events and mode
   input  wire logic              match,
   input  wire logic              wrap,
   input  wire tws_pkg::tws_wave_t mode,
   input  wire logic              flip,
   // pin
   output logic                   wave_ff
);
   import tws_pkg::*;

   logic state_ff;
   logic nxt_state;
   logic nxt_wave;

   // waveform action on match and wraparound
   always_comb begin
      nxt_state = state_ff;
      case (mode)
         WG_NORMAL_FREQ: begin
            if (match) nxt_state = ~state_ff;
         end
         WG_MATCH_FREQ: begin
            if (match ^ wrap) nxt_state = ~state_ff;
         end
         default: begin
            if (match) nxt_state = 1'b1;
            else if (wrap) nxt_state = 1'b0;
         end
      endcase
      nxt_wave = nxt_state ^ flip;
   end

   // register raw level and pin level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= 1'b0;
         wave_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         wave_ff  <= nxt_wave;
      end
   end

   a_freq_toggle : assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == WG_NORMAL_FREQ && match) |=> (state_ff != $past(state_ff)))
      else $error("normal freq mode did not toggle on match");

   a_pulse_clear : assert property (@(posedge aclk) disable iff (!aresetn)
      ((mode == WG_NORMAL_PULSE || mode == WG_MATCH_PULSE) && wrap && !match)
      |=> !state_ff)
      else $error("pulse mode did not clear on wraparound");

endmodule // tws_wave_chan

/* hw/tws_top.sv */
// timer interrupt, status, waveform and polarity registers behind AXI4-Lite
// Notes on behaviour
// - writing one to enable set sets enable
// - writing zero leaves enables and flags unchanged
// - set and clear registers share enables
// - match or capture sets channel flag
// - enabled channel flag requests an interrupt
// - writing one clears a channel flag
// - capture mode: value read clears flag
// - capture onto set flag sets error
// - writing one clears error or overflow
// - overflow sets flag, requests when enabled
// - buffer write sets compare buffer-valid bit
// - update clears buffer-valid; locked write-one clears
// - capture buffer-valid set on store, read clears
// - client bit shows host in 32-bit
// - stopped bit one at reset, stop, disable
// - frequency modes: top choice and toggle actions
// - pulse modes: set on match, clear wrap
// - match modes: channel 0 top; else period top in 8-bit, else maximum
// - polarity flip inverts output and capture pin
// - update lock blocks buffer copy on update
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module tws_top (
   // clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // axi4-lite write address
   input  wire logic [tws_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // axi4-lite read
   input  wire logic [tws_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // counter core
   input  wire tws_pkg::tws_core_t          core,
   output tws_pkg::tws_top_t                top_sel_ff,
   output logic                             copy_ok_ff,
   // pins
   input  wire logic [tws_pkg::NUM_CH-1:0]  capture_pin,
   output logic [tws_pkg::NUM_CH-1:0]       capture_trig_ff,
   output logic [tws_pkg::NUM_CH-1:0]       waveform_out,
   // interrupt
   output logic                             irq_ff
);
   import tws_pkg::*;

   // address to register decode, shared by read and write
   function automatic tws_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] idx;
      idx = addr >> IDX_SHIFT;
      if (addr[IDX_SHIFT-1:0] != 2'h0) decode = SEL_NONE;
      else if (idx == IDX_EN_CLR) decode = SEL_EN_CLR;
      else if (idx == IDX_EN_SET) decode = SEL_EN_SET;
      else if (idx == IDX_FLAGS) decode = SEL_FLAGS;
      else if (idx == IDX_STATUS) decode = SEL_STATUS;
      else if (idx == IDX_WAVE) decode = SEL_WAVE;
      else if (idx == IDX_POLAR) decode = SEL_POLAR;
      else decode = SEL_NONE;
   endfunction

   logic              aw_held_ff, nxt_aw_held;
   logic              w_held_ff, nxt_w_held;
   logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
   logic [7:0]        wbyte_ff, nxt_wbyte;
   logic              wlane_ff, nxt_wlane;
   logic              nxt_awready, nxt_wready, nxt_bvalid;
   logic [1:0]        nxt_bresp;
   logic              wr_fire;
   tws_sel_t          wr_sel;

   // write channel: take address and data in either order
   always_comb begin
      wr_sel      = decode(awaddr_ff);
      wr_fire     = aw_held_ff && w_held_ff && !s_axi_bvalid;
      nxt_aw_held = aw_held_ff;
      nxt_w_held  = w_held_ff;
      nxt_awaddr  = awaddr_ff;
      nxt_wbyte   = wbyte_ff;
      nxt_wlane   = wlane_ff;
      nxt_bvalid  = s_axi_bvalid;
      nxt_bresp   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw_held = 1'b1;
         nxt_awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w_held = 1'b1;
         nxt_wbyte  = s_axi_wdata[7:0];
         nxt_wlane  = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) nxt_bvalid = 1'b0;
      if (wr_fire) begin
         nxt_aw_held = 1'b0;
         nxt_w_held  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      nxt_awready = !nxt_aw_held && !nxt_bvalid;
      nxt_wready  = !nxt_w_held && !nxt_bvalid;
   end

   // write channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         awaddr_ff     <= '0;
         wbyte_ff      <= 8'h00;
         wlane_ff      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         aw_held_ff    <= nxt_aw_held;
         w_held_ff     <= nxt_w_held;
         awaddr_ff     <= nxt_awaddr;
         wbyte_ff      <= nxt_wbyte;
         wlane_ff      <= nxt_wlane;
         s_axi_awready <= nxt_awready;
         s_axi_wready  <= nxt_wready;
         s_axi_bvalid  <= nxt_bvalid;
         s_axi_bresp   <= nxt_bresp;
      end
   end

   logic [7:0] enable_ff, nxt_enable;
   logic [7:0] flags_ff, nxt_flags;
   logic [7:0] status_ff, nxt_status;
   logic [1:0] wave_ff, nxt_wave;
   logic [1:0] polar_ff, nxt_polar;
   logic [7:0] wr_set, wr_clr, wr_flag, wr_stat;

   // register state: enables, flags, status and configuration
   always_comb begin
      wr_set     = (wr_fire && wlane_ff && wr_sel == SEL_EN_SET) ? wbyte_ff : 8'h00;
      wr_clr     = (wr_fire && wlane_ff && wr_sel == SEL_EN_CLR) ? wbyte_ff : 8'h00;
      wr_flag    = (wr_fire && wlane_ff && wr_sel == SEL_FLAGS) ? wbyte_ff : 8'h00;
      wr_stat    = (wr_fire && wlane_ff && wr_sel == SEL_STATUS) ? wbyte_ff : 8'h00;
      nxt_enable = ((enable_ff | wr_set) & ~wr_clr) & IRQ_MASK;
      nxt_flags  = flags_ff;
      nxt_status = status_ff;
      nxt_wave   = wave_ff;
      nxt_polar  = polar_ff;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         // hardware set wins over any clear in the same cycle
         nxt_flags[BIT_MC0+ch] = core.match[ch] || core.capture[ch]
            || (flags_ff[BIT_MC0+ch] && !wr_flag[BIT_MC0+ch]
            && !(core.capture_mode[ch] && core.cc_read[ch]));
         if (core.capture_mode[ch]) begin
            nxt_status[BIT_BUFV0+ch] = core.capture[ch]
               || (status_ff[BIT_BUFV0+ch] && !core.cc_read[ch]);
         end else begin
            nxt_status[BIT_BUFV0+ch] = core.buf_write[ch]
               || (status_ff[BIT_BUFV0+ch] && !core.update
               && !(core.update_lock && wr_stat[BIT_BUFV0+ch]));
         end
      end
      nxt_flags[BIT_ERR] = |(core.capture & flags_ff[BIT_MC0 +: NUM_CH])
         || (flags_ff[BIT_ERR] && !wr_flag[BIT_ERR]);
      nxt_flags[BIT_OVF] = core.overflow
         || (flags_ff[BIT_OVF] && !wr_flag[BIT_OVF]);
      nxt_status[BIT_CLNT] = core.is_client && core.host_32bit;
      if (!core.enable || core.stop_cmd || (core.overflow && core.single_shot))
         nxt_status[BIT_STOP] = 1'b1;
      else if (core.start_cmd)
         nxt_status[BIT_STOP] = 1'b0;
      if (wr_fire && wlane_ff && wr_sel == SEL_WAVE) nxt_wave = wbyte_ff[1:0];
      if (wr_fire && wlane_ff && wr_sel == SEL_POLAR) nxt_polar = wbyte_ff[1:0];
   end

   // register state flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_ff <= RST_ENABLE;
         flags_ff  <= RST_FLAGS;
         status_ff <= RST_STATUS;
         wave_ff   <= RST_WAVE[1:0];
         polar_ff  <= RST_POLAR[1:0];
      end else begin
         enable_ff <= nxt_enable;
         flags_ff  <= nxt_flags;
         status_ff <= nxt_status;
         wave_ff   <= nxt_wave;
         polar_ff  <= nxt_polar;
      end
   end

   logic        nxt_arready, nxt_rvalid;
   logic [31:0] nxt_rdata;
   logic [1:0]  nxt_rresp;
   tws_sel_t    rd_sel;

   // read channel: data one cycle after address is taken
   always_comb begin
      rd_sel      = decode(s_axi_araddr);
      nxt_arready = s_axi_arready;
      nxt_rvalid  = s_axi_rvalid;
      nxt_rdata   = s_axi_rdata;
      nxt_rresp   = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_rvalid  = 1'b0;
         nxt_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_arready = 1'b0;
         nxt_rvalid  = 1'b1;
         nxt_rresp   = RESP_OKAY;
         nxt_rdata   = 32'h0000_0000;
         if (rd_sel == SEL_EN_CLR || rd_sel == SEL_EN_SET)
            nxt_rdata[7:0] = enable_ff;
         else if (rd_sel == SEL_FLAGS) nxt_rdata[7:0] = flags_ff;
         else if (rd_sel == SEL_STATUS) nxt_rdata[7:0] = status_ff;
         else if (rd_sel == SEL_WAVE) nxt_rdata[1:0] = wave_ff;
         else if (rd_sel == SEL_POLAR) nxt_rdata[1:0] = polar_ff;
         else nxt_rresp = RESP_SLVERR;
      end
   end

   // read channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= nxt_arready || (!s_axi_arready && !s_axi_rvalid);
         s_axi_rvalid  <= nxt_rvalid;
         s_axi_rdata   <= nxt_rdata;
         s_axi_rresp   <= nxt_rresp;
      end
   end

   tws_top_t          nxt_top;
   logic              nxt_irq, nxt_copy_ok;
   logic [NUM_CH-1:0] nxt_trig;

   // core-facing outputs and interrupt request
   always_comb begin
      if (wave_ff == WG_MATCH_FREQ || wave_ff == WG_MATCH_PULSE)
         nxt_top = TOP_CH0;
      else if (core.cnt_mode == CNT_8BIT)
         nxt_top = TOP_PERIOD;
      else
         nxt_top = TOP_MAX;
      nxt_irq     = |(flags_ff & enable_ff & IRQ_MASK);
      nxt_copy_ok = core.update && !core.update_lock;
      nxt_trig    = capture_pin ^ polar_ff;
   end

   // output flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         top_sel_ff      <= TOP_MAX;
         irq_ff          <= 1'b0;
         copy_ok_ff      <= 1'b0;
         capture_trig_ff <= '0;
      end else begin
         top_sel_ff      <= nxt_top;
         irq_ff          <= nxt_irq;
         copy_ok_ff      <= nxt_copy_ok;
         capture_trig_ff <= nxt_trig;
      end
   end

   // waveform generators, one per channel
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_wave
      tws_wave_chan u_chan (
         .aclk    (aclk),
         .aresetn (aresetn),
         .match   (core.match[ch]),
         .wrap    (core.wrap),
         .mode    (tws_wave_t'(wave_ff)),
         .flip    (polar_ff[ch]),
         .wave_ff (waveform_out[ch])
      );
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_flag_write(int b);
      wr_fire && wlane_ff && wr_sel == SEL_FLAGS && wbyte_ff[b];
   endsequence

   sequence s_quiet_events;
      core.match == '0 && core.capture == '0 && !core.overflow;
   endsequence

   a_enable_set : assert property (wr_fire && wlane_ff && wr_sel == SEL_EN_SET
      && wbyte_ff[BIT_MC0] |=> enable_ff[BIT_MC0])
      else $error("enable set write did not set enable");

   a_zero_write : assert property ((wr_fire && wr_sel == SEL_FLAGS && wbyte_ff == 8'h00
      && core.cc_read == '0) ##0 s_quiet_events |=> $stable(flags_ff))
      else $error("zero write changed flags");

   a_enable_shared : assert property (wr_fire && wlane_ff && wr_sel == SEL_EN_CLR
      && wbyte_ff[BIT_OVF] && !wr_set[BIT_OVF] |=> !enable_ff[BIT_OVF])
      else $error("enable clear not reflected in shared enables");

   a_match_flag : assert property (core.match[0] |=> flags_ff[BIT_MC0])
      else $error("match did not set channel flag");

   a_flag_clear : assert property (s_flag_write(BIT_MC0) ##0 !core.match[0]
      && !core.capture[0] |=> !flags_ff[BIT_MC0])
      else $error("write one did not clear channel flag");

   a_error_set : assert property (core.capture[1] && flags_ff[BIT_MC0+1]
      |=> flags_ff[BIT_ERR])
      else $error("capture overrun did not set error");

   a_overflow_irq : assert property (core.overflow && enable_ff[BIT_OVF]
      && !wr_clr[BIT_OVF] |=> ##1 irq_ff)
      else $error("overflow did not raise interrupt within two cycles");

   a_irq_follow : assert property (##1 irq_ff == $past(|(flags_ff & enable_ff)))
      else $error("interrupt output does not follow flags and enables");

   a_bufv_set : assert property (core.buf_write[0] && !core.capture_mode[0]
      |=> status_ff[BIT_BUFV0])
      else $error("buffer write did not set buffer valid");

   a_stop_disabled : assert property (!core.enable |=> status_ff[BIT_STOP])
      else $error("stopped bit clear while counter disabled");

   a_update_lock : assert property (copy_ok_ff |-> $past(!core.update_lock)
      && $past(core.update))
      else $error("buffer copy allowed under update lock");

endmodule // tws_top

/* verif/tws_top_tb.sv */
// self-checking testbench of the timer status and waveform slice
`timescale 1ns/1ps
module tws_top_tb;
   import tws_pkg::*;

   // one table row: write index and data, read index and expected byte
   typedef struct packed {
      logic [7:0] wa;
      logic [7:0] wd;
      logic [7:0] ra;
      logic [7:0] ex;
   } tws_row_t;

   // clock, reset and bus
   logic              aclk, aresetn;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0]       s_axi_wdata, s_axi_rdata, d;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp, r;
   // core side and pins
   tws_core_t         core, base, p;
   tws_top_t          top_sel_ff;
   logic              copy_ok_ff, irq_ff, seen_copy;
   logic [NUM_CH-1:0] capture_pin, capture_trig_ff, waveform_out;
   tws_row_t          rows [8];
   int                errors, checks;

   tws_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .core(core), .top_sel_ff(top_sel_ff), .copy_ok_ff(copy_ok_ff),
      .capture_pin(capture_pin), .capture_trig_ff(capture_trig_ff),
      .waveform_out(waveform_out), .irq_ff(irq_ff));

   // 25 mhz clock
   always #20 aclk = ~aclk;

   // compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // bus write by register index, response code returned
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= {a[5:0], 2'b00};
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (s_axi_bvalid !== 1'b1) errors++;
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // bus read by register index
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= {a[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (s_axi_rvalid !== 1'b1) errors++;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // read a register and compare data and response
   task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
      logic [31:0] v;
      logic [1:0]  rs;
      rd(a, v, rs);
      chk($sformatf("reg %h", a), v, {24'h00_0000, ex});
      chk("rresp", 32'(rs), 32'(RESP_OKAY));
   endtask

   // apply level changes of the core group
   task automatic lvl;
      @(posedge aclk);
      core <= base;
   endtask

   // one-cycle core event, copy strobe sampled in its cycle
   task automatic pulse(input int k);
      @(posedge aclk);
      p = base;
      case (k)
         0: p.match[0] = 1'b1;
         1: p.capture[1] = 1'b1;
         2: p.cc_read[1] = 1'b1;
         3: p.overflow = 1'b1;
         4: p.buf_write[0] = 1'b1;
         5: p.update = 1'b1;
         6: p.wrap = 1'b1;
         7: p.start_cmd = 1'b1;
         default: p.stop_cmd = 1'b1;
      endcase
      core <= p;
      @(posedge aclk);
      core <= base;
      @(posedge aclk);
      seen_copy = copy_ok_ff;
      @(posedge aclk);
   endtask

   // top source two edges after a mode change
   task automatic tchk(input tws_top_t e);
      repeat (2) @(posedge aclk);
      chk("top", 32'(top_sel_ff), 32'(e));
   endtask

   task automatic done(input string nm);
      $display("test %s done, errors %0d", nm, errors);
   endtask

   // verdict and end of run
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      give_verdict();
   end

   // main sequence
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      base = '0;
      base.cnt_mode = CNT_16BIT;
      core = base;
      capture_pin = 2'b00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      errors = 0;
      checks = 0;
      rows[0] = '{IDX_EN_SET, 8'h33, IDX_EN_SET, 8'h33};
      rows[1] = '{IDX_EN_SET, 8'h00, IDX_EN_SET, 8'h33};
      rows[2] = '{IDX_EN_CLR, 8'h01, IDX_EN_SET, 8'h32};
      rows[3] = '{IDX_EN_CLR, 8'h32, IDX_EN_CLR, 8'h00};
      rows[4] = '{IDX_EN_SET, 8'h33, IDX_EN_CLR, 8'h33};
      rows[5] = '{IDX_FLAGS, 8'hff, IDX_FLAGS, 8'h00};
      rows[6] = '{IDX_WAVE, 8'h03, IDX_WAVE, 8'h03};
      rows[7] = '{IDX_POLAR, 8'h02, IDX_POLAR, 8'h02};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(IDX_EN_SET, 8'h00);
      rchk(IDX_FLAGS, 8'h00);
      rchk(IDX_STATUS, 8'h01);
      rchk(IDX_WAVE, 8'h00);
      rchk(IDX_POLAR, 8'h00);
      done("reset");
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd, r);
         rchk(rows[i].ra, rows[i].ex);
      end
      done("table");
      // flags, enables and request line
      pulse(0);
      rchk(IDX_FLAGS, 8'h10);
      chk("irq", 32'(irq_ff), 32'h1);
      wr(IDX_FLAGS, 8'h00, r);
      rchk(IDX_FLAGS, 8'h10);
      wr(IDX_FLAGS, 8'h10, r);
      rchk(IDX_FLAGS, 8'h00);
      chk("irq", 32'(irq_ff), 32'h0);
      pulse(3);
      rchk(IDX_FLAGS, 8'h01);
      chk("irq", 32'(irq_ff), 32'h1);
      wr(IDX_EN_CLR, 8'h01, r);
      rchk(IDX_EN_SET, 8'h32);
      chk("irq", 32'(irq_ff), 32'h0);
      wr(IDX_FLAGS, 8'h01, r);
      rchk(IDX_FLAGS, 8'h00);
      done("flags");
      // capture channel one: store, overrun, read clear
      base.capture_mode = 2'b10;
      pulse(1);
      rchk(IDX_FLAGS, 8'h20);
      rchk(IDX_STATUS, 8'h21);
      pulse(1);
      rchk(IDX_FLAGS, 8'h22);
      pulse(2);
      rchk(IDX_FLAGS, 8'h02);
      rchk(IDX_STATUS, 8'h01);
      wr(IDX_FLAGS, 8'h02, r);
      rchk(IDX_FLAGS, 8'h00);
      done("capture");
      // compare buffer valid and update lock
      pulse(4);
      rchk(IDX_STATUS, 8'h11);
      wr(IDX_STATUS, 8'h10, r);
      rchk(IDX_STATUS, 8'h11);
      base.update_lock = 1'b1;
      lvl();
      wr(IDX_STATUS, 8'h10, r);
      rchk(IDX_STATUS, 8'h01);
      wr(IDX_STATUS, 8'h10, r);
      rchk(IDX_STATUS, 8'h01);
      pulse(4);
      rchk(IDX_STATUS, 8'h11);
      pulse(5);
      chk("copy", 32'(seen_copy), 32'h0);
      base.update_lock = 1'b0;
      pulse(4);
      pulse(5);
      chk("copy", 32'(seen_copy), 32'h1);
      rchk(IDX_STATUS, 8'h01);
      done("buffer");
      // run state and chained client
      base.enable = 1'b1;
      lvl();
      pulse(7);
      rchk(IDX_STATUS, 8'h00);
      base.is_client = 1'b1;
      base.host_32bit = 1'b1;
      lvl();
      rchk(IDX_STATUS, 8'h02);
      pulse(8);
      rchk(IDX_STATUS, 8'h03);
      pulse(7);
      base.single_shot = 1'b1;
      pulse(3);
      rchk(IDX_STATUS, 8'h03);
      done("status");
      // top value source per mode and counter width
      wr(IDX_WAVE, 8'h01, r);
      tchk(TOP_CH0);
      wr(IDX_WAVE, 8'h02, r);
      tchk(TOP_MAX);
      base.cnt_mode = CNT_8BIT;
      lvl();
      tchk(TOP_PERIOD);
      base.cnt_mode = CNT_32BIT;
      lvl();
      tchk(TOP_MAX);
      wr(IDX_WAVE, 8'h03, r);
      tchk(TOP_CH0);
      done("top");
      // waveform actions and polarity flip
      wr(IDX_POLAR, 8'h00, r);
      wr(IDX_WAVE, 8'h02, r);
      pulse(6);
      chk("wave", 32'(waveform_out[0]), 32'h0);
      pulse(0);
      chk("wave", 32'(waveform_out[0]), 32'h1);
      wr(IDX_POLAR, 8'h01, r);
      capture_pin <= 2'b10;
      repeat (2) @(posedge aclk);
      chk("wave", 32'(waveform_out[0]), 32'h0);
      chk("trig", 32'(capture_trig_ff), 32'h3);
      wr(IDX_WAVE, 8'h00, r);
      pulse(6);
      chk("wave", 32'(waveform_out[0]), 32'h0);
      pulse(0);
      chk("wave", 32'(waveform_out[0]), 32'h1);
      wr(IDX_WAVE, 8'h01, r);
      pulse(6);
      chk("wave", 32'(waveform_out), 32'h2);
      done("wave");
      // unmapped place and a second reset
      wr(8'h0f, 8'h01, r);
      chk("bresp", 32'(r), 32'(RESP_SLVERR));
      rd(8'h0f, d, r);
      chk("rresp", 32'(r), 32'(RESP_SLVERR));
      chk("rdata", d, 32'h0);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(IDX_EN_SET, 8'h00);
      rchk(IDX_FLAGS, 8'h00);
      chk("irq", 32'(irq_ff), 32'h0);
      done("rereset");
      give_verdict();
   end
endmodule // tws_top_tb
